// ---- verilog/rcr_pkg.sv ----
// Constants, register map and types for the regulator control registers.
// Assumes a single 25 MHz core clock and an I2C target front end.
package rcr_pkg;

   // ------------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_SETPOINT    = 8'h00;
   localparam logic [7:0] ADDR_CTL_ONE     = 8'h01;
   localparam logic [7:0] ADDR_CTL_TWO     = 8'h02;
   localparam logic [7:0] ADDR_CTL_THREE   = 8'h03;
   localparam logic [7:0] ADDR_FAULT       = 8'h04;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int BIT_DEV_RESET  = 7;
   localparam int BIT_SPREAD     = 6;
   localparam int BIT_SWITCH     = 5;
   localparam int BIT_FPWM       = 4;
   localparam int BIT_DISCH      = 3;
   localparam int BIT_HICCUP     = 2;
   localparam int RAMP_LSB       = 0;
   localparam int RANGE_LSB      = 2;
   localparam int FAULT_BITS     = 6;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] CTL_ONE_RST   = 8'h2A;
   localparam logic [7:0] CTL_TWO_RST   = 8'h0A;
   localparam logic [7:0] CTL_THREE_RST = 8'h00;
   localparam logic [7:0] READ_EMPTY    = 8'h00;

   // ------------------------------------------------------------------
   // Voltage scaling, microvolts and microvolts per microsecond
   // ------------------------------------------------------------------
   localparam logic [20:0] BASE_UV        = 21'h061A80; // 0.4 V
   localparam logic [12:0] STEP_FINE_UV   = 13'h04E2;   // 1.25 mV
   localparam logic [12:0] STEP_MID_UV    = 13'h09C4;   // 2.5 mV
   localparam logic [12:0] STEP_COARSE_UV = 13'h1388;   // 5 mV
   localparam logic [1:0]  RANGE_FINE     = 2'h0;
   localparam logic [1:0]  RANGE_MID      = 2'h1;
   localparam logic [13:0] SLEW_FAST      = 14'h2710;   // 10 mV/us
   localparam logic [13:0] SLEW_MID       = 14'h1388;   // 5 mV/us
   localparam logic [13:0] SLEW_SLOW      = 14'h04E2;   // 1.25 mV/us
   localparam logic [13:0] SLEW_CRAWL     = 14'h01F4;   // 0.5 mV/us

   // ------------------------------------------------------------------
   // Timing counts in core clock cycles
   // ------------------------------------------------------------------
   localparam logic [2:0] PIN_SETTLE_CYC  = 3'h3;  // Two sync flops + 1
   localparam logic [2:0] RESTART_HOLD    = 3'h4;

   typedef enum logic [3:0] {
      S_IDLE, S_ADDR, S_ADDR_ACK, S_REG, S_REG_ACK,
      S_WDATA, S_WDATA_ACK, S_RDATA, S_RDATA_ACK, S_IGNORE
   } rcr_i2c_state_t;

endpackage

// ---- verilog/rcr_vout_calc.sv ----
// Converts setpoint code, range and ramp select into target voltage
// and slew rate. Assumes inputs come from flops on the same clock.
`timescale 1ns/100ps
module rcr_vout_calc
   import rcr_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  setpoint,
   input  wire logic [1:0]  range_sel,
   input  wire logic [1:0]  ramp_sel,
   output logic      [20:0] target_uv_q,
   output logic      [13:0] slew_q
);

   // ------------------------------------------------------------------
   // Step size per range
   // ------------------------------------------------------------------
   function automatic logic [12:0] step_of(input logic [1:0] r);
      unique case (r)
         RANGE_FINE: step_of = STEP_FINE_UV;
         RANGE_MID:  step_of = STEP_MID_UV;
         default:    step_of = STEP_COARSE_UV; // Both upper codes coarse
      endcase
   endfunction

   logic [20:0] target_uv_d;
   logic [13:0] slew_d;

   // Setpoint arithmetic and ramp decode
   always_comb
   begin
      target_uv_d = BASE_UV + 21'(setpoint) * 21'(step_of(range_sel));
      unique case (ramp_sel)
         2'h0:    slew_d = SLEW_FAST;
         2'h1:    slew_d = SLEW_MID;
         2'h2:    slew_d = SLEW_SLOW;
         default: slew_d = SLEW_CRAWL;
      endcase
   end

   // Registered so the outputs of the top come from flops
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         target_uv_q <= BASE_UV;
         slew_q      <= SLEW_SLOW;
      end
      else
      begin
         target_uv_q <= target_uv_d;
         slew_q      <= slew_d;
      end
   end

   a_target_calc : assert property (@(posedge core_clk) disable iff (!rst_b)
      ##1 target_uv_q == BASE_UV + 21'($past(setpoint))
          * 21'(step_of($past(range_sel))))
      else $error("target voltage does not follow setpoint and range");

   a_slew_slowest : assert property (@(posedge core_clk) disable iff (!rst_b)
      (ramp_sel == 2'h3) |=> (slew_q == SLEW_CRAWL))
      else $error("ramp code 3 did not give the slowest slew");

endmodule

// ---- verilog/rcr_regs.sv ----
// Register bank of a step-down regulator behind an I2C target port.
// Assumes SCL/SDA and the strap pins are asynchronous; fault events
// come from logic on core_clk. SDA is open drain, resolved outside.
//
// How it works
// - Five byte registers at offsets 0 to 4
// - Target is 0.4 V plus code times step
// - Setpoint loaded from sampled voltage-select pin
// - Device reset restarts, resamples strap, defaults
// - Device-reset bit always reads zero
// - Bit 6 enables spread spectrum, resets zero
// - Bit 5 gates switching, resets one
// - Bit 4 or mode pin forces PWM
// - Bit 3 enables output discharge, resets one
// - Bit 2 enables hiccup; keep clear stacked
// - Bits 1-0 pick the output slew rate
// - Control one resets to 2Ah
// - Range field picks 1.25, 2.5, 5 mV
// - Data byte commits at falling ACK edge
// - Unmapped offsets read back as 00h
`timescale 1ns/100ps
module rcr_regs
   import rcr_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR      = 7'h3C,  // Arbitrary value
   parameter logic [7:0] VOLTAGE_SELECT_PIN_LOW_CODE = 8'h00,
   parameter logic [7:0] VOLTAGE_SELECT_PIN_HIGH_CODE = 8'h50,
   parameter logic [7:0] SYNC_HOLD_CYC = 8'h40
)
(
   input  wire logic                  core_clk,
   input  wire logic                  rst_b,
   input  wire logic                  scl_pin,
   input  wire logic                  sda_pin_in,
   output logic                       sda_pin_out,
   output logic                       sda_pin_oe_b,
   input  wire logic                  voltage_select_pin,
   input  wire logic                  mode_sync_pin,
   input  wire logic [FAULT_BITS-1:0] fault_event,
   output logic      [7:0]            output_setpoint,
   output logic                       spread_spectrum_on,
   output logic                       switching_on,
   output logic                       forced_pwm_on,
   output logic                       output_discharge_on,
   output logic                       hiccup_on,
   output logic      [1:0]            ramp_rate_select,
   output logic      [1:0]            voltage_range_select,
   output logic      [7:0]            control_three,
   output logic                       power_down,
   output logic                       restart_pulse,
   output logic      [20:0]           target_uv,
   output logic      [13:0]           slew_uv_per_us
);

   // ------------------------------------------------------------------
   // Pin synchronisers; edges use stage two and three only
   // ------------------------------------------------------------------
   logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
   logic voltage_select_pin_s1, voltage_select_pin_s2, mode_s1, mode_s2, mode_s3;

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         {scl_s1, scl_s2, scl_s3} <= 3'h7;
         {sda_s1, sda_s2, sda_s3} <= 3'h7;
         {voltage_select_pin_s1, voltage_select_pin_s2}       <= 2'h0;
         {mode_s1, mode_s2, mode_s3} <= 3'h0;
      end
      else
      begin
         {scl_s1, scl_s2, scl_s3} <= {scl_pin, scl_s1, scl_s2};
         {sda_s1, sda_s2, sda_s3} <= {sda_pin_in, sda_s1, sda_s2};
         {voltage_select_pin_s1, voltage_select_pin_s2}       <= {voltage_select_pin, voltage_select_pin_s1};
         {mode_s1, mode_s2, mode_s3} <= {mode_sync_pin, mode_s1, mode_s2};
      end
   end

   logic scl_rise, scl_fall, bus_start, bus_stop;
   assign scl_rise  = scl_s2 & ~scl_s3;
   assign scl_fall  = ~scl_s2 & scl_s3;
   assign bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
   assign bus_stop  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

   // ------------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------------
   logic [7:0] setpoint_q, setpoint_d, ctl_two_q, ctl_two_d;
   logic [7:0] ctl_three_q, ctl_three_d;
   logic [6:0] ctl_one_q, ctl_one_d;    // Reset bit is never stored
   logic [FAULT_BITS-1:0] fault_q, fault_d;
   logic [2:0] settle_q, settle_d, hold_q, hold_d;
   logic [7:0] sync_cnt_q, sync_cnt_d;
   logic       switch_q, switch_d, fpwm_q, fpwm_d, restart_q, restart_d;
   logic       wr_commit, rd_fault;

   // Read data; bit 7 of control one and unmapped offsets read zero
   function automatic logic [7:0] read_mux(input logic [7:0] a);
      unique case (a)
         ADDR_SETPOINT:  read_mux = setpoint_q;
         ADDR_CTL_ONE:   read_mux = {1'b0, ctl_one_q};
         ADDR_CTL_TWO:   read_mux = ctl_two_q;
         ADDR_CTL_THREE: read_mux = ctl_three_q;
         ADDR_FAULT:     read_mux = {2'h0, fault_q};
         default:        read_mux = READ_EMPTY;
      endcase
   endfunction

   // ------------------------------------------------------------------
   // I2C target engine
   // ------------------------------------------------------------------
   rcr_i2c_state_t state_q, state_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] shreg_q, shreg_d, tx_q, tx_d, ptr_q, ptr_d;
   logic       rw_q, rw_d, oe_b_q, oe_b_d, nack_q, nack_d;
   logic [7:0] rd_byte;                 // Byte loaded for a read

   // Bits sample on SCL rise, SDA changes only after SCL fall
   always_comb
   begin
      state_d = state_q;
      cnt_d   = cnt_q;
      shreg_d = shreg_q;
      tx_d    = tx_q;
      ptr_d   = ptr_q;
      rw_d    = rw_q;
      oe_b_d  = oe_b_q;
      nack_d  = nack_q;
      wr_commit = 1'b0;
      rd_fault  = 1'b0;
      rd_byte   = 8'h00;
      if (bus_stop)
      begin
         state_d = S_IDLE;
         oe_b_d  = 1'b1;
      end
      else if (bus_start)
      begin
         state_d = S_ADDR;      // Also covers repeated start
         cnt_d   = 4'h0;
         oe_b_d  = 1'b1;
      end
      else if (scl_rise)
      begin
         if (state_q == S_ADDR || state_q == S_REG || state_q == S_WDATA)
         begin
            shreg_d = {shreg_q[6:0], sda_s2};
            cnt_d   = cnt_q + 4'h1;
         end
         else if (state_q == S_RDATA_ACK)
            nack_d = sda_s2;
      end
      else if (scl_fall)
      begin
         unique case (state_q)
            S_ADDR, S_REG, S_WDATA:
               if (cnt_q == 4'h8)
               begin
                  if (state_q == S_ADDR && shreg_q[7:1] != DEV_ADDR)
                     state_d = S_IGNORE;
                  else
                  begin
                     oe_b_d  = 1'b0;   // Acknowledge the byte
                     state_d = (state_q == S_ADDR) ? S_ADDR_ACK :
                               (state_q == S_REG)  ? S_REG_ACK  :
                                                     S_WDATA_ACK;
                     if (state_q == S_ADDR)
                        rw_d = shreg_q[0];
                     if (state_q == S_REG)
                        ptr_d = shreg_q;
                  end
               end
            S_ADDR_ACK, S_RDATA_ACK:
               if (state_q == S_RDATA_ACK && nack_q)
               begin
                  oe_b_d  = 1'b1;
                  state_d = S_IGNORE;
               end
               else if (state_q == S_ADDR_ACK && !rw_q)
               begin
                  oe_b_d  = 1'b1;
                  cnt_d   = 4'h0;
                  state_d = S_REG;
               end
               else
               begin
                  // A burst moves on to the next offset before loading
                  if (state_q == S_RDATA_ACK)
                     ptr_d = ptr_q + 8'h01;
                  rd_byte  = read_mux(ptr_d);
                  oe_b_d   = rd_byte[7];         // Low level drives SDA
                  tx_d     = {rd_byte[6:0], 1'b0};
                  rd_fault = (ptr_d == ADDR_FAULT);
                  cnt_d    = 4'h1;
                  state_d  = S_RDATA;
               end
            S_REG_ACK, S_WDATA_ACK:
            begin
               oe_b_d  = 1'b1;
               cnt_d   = 4'h0;
               state_d = S_WDATA;
               if (state_q == S_WDATA_ACK)
               begin
                  wr_commit = 1'b1;
                  ptr_d     = ptr_q + 8'h01;
               end
            end
            S_RDATA:
               if (cnt_q == 4'h8)
               begin
                  oe_b_d  = 1'b1;               // Controller acks now
                  state_d = S_RDATA_ACK;
               end
               else
               begin
                  oe_b_d = tx_q[7];
                  tx_d   = {tx_q[6:0], 1'b0};
                  cnt_d  = cnt_q + 4'h1;
               end
            S_IDLE, S_IGNORE: ;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_q <= S_IDLE;
         cnt_q   <= 4'h0;
         shreg_q <= 8'h00;
         tx_q    <= 8'h00;
         ptr_q   <= 8'h00;
         rw_q    <= 1'b0;
         oe_b_q  <= 1'b1;
         nack_q  <= 1'b1;
      end
      else
      begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         shreg_q <= shreg_d;
         tx_q    <= tx_d;
         ptr_q   <= ptr_d;
         rw_q    <= rw_d;
         oe_b_q  <= oe_b_d;
         nack_q  <= nack_d;
      end
   end

   // ------------------------------------------------------------------
   // Register updates, device reset and pin-derived outputs
   // ------------------------------------------------------------------
   // Unlisted offsets simply drop writes; controller keeps off them
   always_comb
   begin
      setpoint_d  = setpoint_q;
      ctl_one_d   = ctl_one_q;
      ctl_two_d   = ctl_two_q;
      ctl_three_d = ctl_three_q;
      settle_d    = (settle_q != 3'h0) ? settle_q - 3'h1 : 3'h0;
      hold_d      = (hold_q != 3'h0) ? hold_q - 3'h1 : 3'h0;
      restart_d   = 1'b0;
      // Status flags: a new event wins over a clear by read
      fault_d = (fault_q & {FAULT_BITS{~rd_fault}}) | fault_event;
      if (wr_commit)
      begin
         unique case (ptr_q)
            ADDR_SETPOINT:  setpoint_d  = shreg_q;
            ADDR_CTL_ONE:   ctl_one_d   = shreg_q[6:0];
            ADDR_CTL_TWO:   ctl_two_d   = shreg_q;
            ADDR_CTL_THREE: ctl_three_d = shreg_q;
            default: ;
         endcase
         if (ptr_q == ADDR_CTL_ONE && shreg_q[BIT_DEV_RESET])
         begin
            ctl_one_d   = CTL_ONE_RST[6:0];
            ctl_two_d   = CTL_TWO_RST;
            ctl_three_d = CTL_THREE_RST;
            fault_d     = fault_event;
            settle_d    = PIN_SETTLE_CYC;
            hold_d      = RESTART_HOLD;
            restart_d   = 1'b1;
         end
      end
      if (settle_q == 3'h1)
         setpoint_d = voltage_select_pin_s2 ? VOLTAGE_SELECT_PIN_HIGH_CODE : VOLTAGE_SELECT_PIN_LOW_CODE;
      sync_cnt_d = (mode_s2 ^ mode_s3) ? SYNC_HOLD_CYC :
                   (sync_cnt_q != 8'h00) ? sync_cnt_q - 8'h01 : 8'h00;
      switch_d = ctl_one_d[BIT_SWITCH] & (hold_d == 3'h0);
      fpwm_d   = ctl_one_d[BIT_FPWM] | mode_s2
                 | (sync_cnt_d != 8'h00);
   end

   // Power-up resamples the strap the same way a device reset does
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         setpoint_q  <= 8'h00;
         ctl_one_q   <= CTL_ONE_RST[6:0];
         ctl_two_q   <= CTL_TWO_RST;
         ctl_three_q <= CTL_THREE_RST;
         fault_q     <= '0;
         settle_q    <= PIN_SETTLE_CYC;
         hold_q      <= RESTART_HOLD;
         sync_cnt_q  <= 8'h00;
         switch_q    <= 1'b0;
         fpwm_q      <= 1'b0;
         restart_q   <= 1'b0;
      end
      else
      begin
         setpoint_q  <= setpoint_d;
         ctl_one_q   <= ctl_one_d;
         ctl_two_q   <= ctl_two_d;
         ctl_three_q <= ctl_three_d;
         fault_q     <= fault_d;
         settle_q    <= settle_d;
         hold_q      <= hold_d;
         sync_cnt_q  <= sync_cnt_d;
         switch_q    <= switch_d;
         fpwm_q      <= fpwm_d;
         restart_q   <= restart_d;
      end
   end

   assign sda_pin_out          = 1'b0;      // Constant, open drain
   assign sda_pin_oe_b         = oe_b_q;
   assign output_setpoint      = setpoint_q;
   assign spread_spectrum_on   = ctl_one_q[BIT_SPREAD];
   assign switching_on         = switch_q;
   assign forced_pwm_on        = fpwm_q;
   assign output_discharge_on  = ctl_one_q[BIT_DISCH];
   assign hiccup_on            = ctl_one_q[BIT_HICCUP];
   assign ramp_rate_select     = ctl_one_q[RAMP_LSB +: 2];
   assign voltage_range_select = ctl_two_q[RANGE_LSB +: 2];
   assign control_three        = ctl_three_q;
   assign power_down           = (hold_q != 3'h0);
   assign restart_pulse        = restart_q;

   rcr_vout_calc u_vout (
      .core_clk    (core_clk),
      .rst_b       (rst_b),
      .setpoint    (setpoint_q),
      .range_sel   (ctl_two_q[RANGE_LSB +: 2]),
      .ramp_sel    (ctl_one_q[RAMP_LSB +: 2]),
      .target_uv_q (target_uv),
      .slew_q      (slew_uv_per_us)
   );

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   a_commit_at_ack : assert property (@(posedge core_clk) disable iff (!rst_b)
      wr_commit |-> (state_q == S_WDATA_ACK && scl_fall))
      else $error("write committed outside the falling ACK edge");

   a_write_lands : assert property (@(posedge core_clk) disable iff (!rst_b)
      (wr_commit && ptr_q == ADDR_CTL_THREE) |=> control_three == $past(shreg_q))
      else $error("control three write did not land");

   a_reset_reads_zero : assert property (@(posedge core_clk) disable iff (!rst_b)
      (state_q == S_ADDR_ACK && scl_fall && rw_q && ptr_q == ADDR_CTL_ONE
       && !bus_start && !bus_stop) |=> !sda_pin_oe_b)
      else $error("device reset bit did not read as zero");

   a_unmapped_zero : assert property (@(posedge core_clk) disable iff (!rst_b)
      (state_q == S_ADDR_ACK && scl_fall && rw_q && ptr_q > ADDR_FAULT
       && !bus_start && !bus_stop) |=> (!sda_pin_oe_b && tx_q == 8'h00))
      else $error("unmapped offset did not read 00h");

   a_restart_defaults : assert property (@(posedge core_clk) disable iff (!rst_b)
      restart_pulse |-> (ctl_one_q == CTL_ONE_RST[6:0]
                         && ctl_two_q == CTL_TWO_RST && power_down))
      else $error("device reset did not restore defaults");

   a_restart_once : assert property (@(posedge core_clk) disable iff (!rst_b)
      restart_pulse |=> !restart_pulse ##1 (settle_q == 3'h1))
      else $error("device reset pulse not single or no resample");

   a_strap_load : assert property (@(posedge core_clk) disable iff (!rst_b)
      (settle_q == 3'h1) |=>
         output_setpoint == ($past(voltage_select_pin_s2) ? VOLTAGE_SELECT_PIN_HIGH_CODE : VOLTAGE_SELECT_PIN_LOW_CODE))
      else $error("setpoint not loaded from voltage-select pin");

   a_pin_forces_pwm : assert property (@(posedge core_clk) disable iff (!rst_b)
      mode_s2 |=> forced_pwm_on)
      else $error("mode pin high did not force PWM");

   a_switch_gate : assert property (@(posedge core_clk) disable iff (!rst_b)
      switching_on |-> (ctl_one_q[BIT_SWITCH] && !power_down))
      else $error("switching on while disabled");

endmodule

// ---- test/rcr_host.sv ----
// I2C bus controller model with byte-wide register tasks.
// Assumes the bench resolves SDA with a pull-up; sda_drv 1 releases.
`timescale 1ns/100ps
module rcr_host
#(
   parameter logic [6:0] ADDR = 7'h3C
)
(
   input  wire logic core_clk,
   input  wire logic sda_in,
   output logic      scl,
   output logic      sda_drv
);
   // Core cycles per bus phase; a larger value models a slow controller
   int half = 8;

   initial
   begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   task automatic tick();
      repeat (half) @(posedge core_clk);
   endtask

   // Data moves only while SCL is low, so no false start or stop
   task automatic bit_io(input logic b, output logic got);
      sda_drv <= b;
      tick();
      scl <= 1'b1;
      tick();
      got = sda_in;
      scl <= 1'b0;
      tick();
   endtask

   task automatic start();
      sda_drv <= 1'b1;
      tick();
      scl <= 1'b1;
      tick();
      sda_drv <= 1'b0;
      tick();
      scl <= 1'b0;
      tick();
   endtask

   task automatic stop();
      sda_drv <= 1'b0;
      tick();
      scl <= 1'b1;
      tick();
      sda_drv <= 1'b1;
      tick();
   endtask

   task automatic xfer(input logic [7:0] d, input logic m_ack,
                       output logic [7:0] r, output logic ack);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r[i]);
      bit_io(m_ack, ack);
   endtask

   task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
                            output logic nak);
      logic [7:0] r;
      logic [2:0] k;
      start();
      xfer({ADDR, 1'b0}, 1'b1, r, k[0]);
      xfer(a, 1'b1, r, k[1]);
      xfer(d, 1'b1, r, k[2]);
      stop();
      nak = |k;
   endtask

   // Last byte is refused with a NACK, which ends the read
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] r;
      logic       k;
      start();
      xfer({ADDR, 1'b0}, 1'b1, r, k);
      xfer(a, 1'b1, r, k);
      start();
      xfer({ADDR, 1'b1}, 1'b1, r, k);
      xfer(8'hFF, 1'b1, d, k);
      stop();
   endtask
endmodule

// ---- test/rcr_regs_bench.sv ----
// Self-checking bench for the regulator register bank.
// Assumes rcr_host drives the bus; SDA is resolved here with a pull-up.
`timescale 1ns/100ps
`define CHK(what, exp, got) \
   tests_run++; \
   if ((got) !== (exp)) \
   begin \
      $display("wrong value %s exp %h got %h", what, exp, got); \
      fail_count++; \
   end
module rcr_regs_bench
   import rcr_pkg::*;
;
   logic        core_clk, rst_b, strap_pin, mode_pin, scl, sda_drv;
   logic        sda_out, sda_oe_b, spread, sw_on, fpwm, disch, hic;
   logic        pdown, rst_pls;
   logic [5:0]  fault;
   logic [7:0]  setp, ctl3, pulses, pd_cyc;
   logic [1:0]  ramp, rng;
   logic [20:0] tgt;
   logic [13:0] slew;
   int          fail_count = 0;
   int          tests_run = 0;
   localparam logic [7:0] VOLTAGE_SELECT_PIN_LOW_CODE_DEF = 8'h00;
   logic [13:0] slew_tbl [4] = '{SLEW_FAST, SLEW_MID, SLEW_SLOW, SLEW_CRAWL};
   logic [12:0] step_tbl [4] = '{STEP_FINE_UV, STEP_MID_UV,
                                 STEP_COARSE_UV, STEP_COARSE_UV};
   wire         sda = sda_drv & (sda_oe_b | sda_out);

   rcr_host host (.core_clk(core_clk), .sda_in(sda), .scl(scl),
                  .sda_drv(sda_drv));

   rcr_regs dut (.core_clk(core_clk), .rst_b(rst_b), .scl_pin(scl),
      .sda_pin_in(sda), .sda_pin_out(sda_out), .sda_pin_oe_b(sda_oe_b),
      .voltage_select_pin(strap_pin), .mode_sync_pin(mode_pin),
      .fault_event(fault), .output_setpoint(setp),
      .spread_spectrum_on(spread), .switching_on(sw_on),
      .forced_pwm_on(fpwm), .output_discharge_on(disch),
      .hiccup_on(hic), .ramp_rate_select(ramp),
      .voltage_range_select(rng), .control_three(ctl3),
      .power_down(pdown), .restart_pulse(rst_pls), .target_uv(tgt),
      .slew_uv_per_us(slew));

   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // Restart activity after power-up, so one write gives one restart;
   // the power-up hold is left out since no restart pulse precedes it
   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         pulses <= 8'h00;
         pd_cyc <= 8'h00;
      end
      else
      begin
         pulses <= pulses + 8'(rst_pls === 1'b1);
         pd_cyc <= pd_cyc + 8'(pdown === 1'b1 &&
                               (pulses != 8'h00 || rst_pls === 1'b1));
      end
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic nak;
      host.write_reg(a, d, nak);
      `CHK("write ack", 1'b0, nak)
   endtask

   task automatic rd(input string what, input logic [7:0] a,
                     input logic [7:0] exp);
      logic [7:0] got;
      host.read_reg(a, got);
      `CHK(what, exp, got)
   endtask

   task automatic tally_and_finish();
      if (fail_count == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Main sequence: defaults, fields, ranges, map, flags, device reset
   initial
   begin
      rst_b <= 1'b0;
      strap_pin <= 1'b1;
      mode_pin <= 1'b0;
      fault <= 6'h00;
      repeat (16) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (10) @(posedge core_clk);
      rd("control one", ADDR_CTL_ONE, CTL_ONE_RST);
      rd("setpoint", ADDR_SETPOINT, 8'h50);
      `CHK("setpoint port", 8'h50, setp)
      `CHK("fields", CTL_ONE_RST[6:0], {spread, sw_on, fpwm, disch, hic, ramp})
      `CHK("target", BASE_UV + 21'h50 * 21'(STEP_COARSE_UV), tgt)
      for (int i = 0; i < 4; i++)
      begin
         wr(ADDR_CTL_ONE, 8'h54 | 8'(i));
         rd("control one", ADDR_CTL_ONE, 8'h54 | 8'(i));
         `CHK("slew", slew_tbl[i], slew)
         `CHK("fields", 5'h15, {spread, sw_on, fpwm, disch, hic})
      end
      wr(ADDR_CTL_ONE, CTL_ONE_RST);
      mode_pin <= 1'b1;
      repeat (8) @(posedge core_clk);
      `CHK("pwm by pin", 1'b1, fpwm)
      mode_pin <= 1'b0;
      repeat (8) @(posedge core_clk);
      `CHK("pwm by sync", 1'b1, fpwm)
      repeat (92) @(posedge core_clk);
      `CHK("power save", 1'b0, fpwm)
      // Setpoint rewritten after every range change
      for (int r = 0; r < 4; r++)
      begin
         wr(ADDR_CTL_TWO, 8'(r) << 2);
         wr(ADDR_SETPOINT, 8'hC8);
         `CHK("target", BASE_UV + 21'(step_tbl[r]) * 21'hC8, tgt)
      end
      wr(ADDR_CTL_THREE, 8'h05);
      rd("control three", ADDR_CTL_THREE, 8'h05);
      `CHK("control three port", 8'h05, ctl3)
      rd("unmapped", 8'h07, READ_EMPTY);
      fault <= 6'h21;
      @(posedge core_clk);
      fault <= 6'h00;
      rd("flags", ADDR_FAULT, 8'h21);
      rd("flags clear", ADDR_FAULT, 8'h00);
      // Device reset issued by a slow controller, strap now low
      host.half = 20;
      strap_pin <= 1'b0;
      wr(ADDR_CTL_ONE, 8'hC0);
      repeat (20) @(posedge core_clk);
      host.half = 8;
      `CHK("restarts", 8'h01, pulses)
      `CHK("hold", 8'h04, pd_cyc)
      rd("control one", ADDR_CTL_ONE, CTL_ONE_RST);
      rd("setpoint", ADDR_SETPOINT, VOLTAGE_SELECT_PIN_LOW_CODE_DEF);
      `CHK("setpoint port", VOLTAGE_SELECT_PIN_LOW_CODE_DEF, setp)
      `CHK("range", 2'h2, rng)
      tally_and_finish();
   end

   // The tests need about 23k cycles; far longer means a hang
   initial
   begin
      repeat (90000) @(posedge core_clk);
      fail_count++;
      tally_and_finish();
   end
endmodule
